/* design/drf_pkg.sv */
package drf_pkg;

  // storage geometry
  localparam int ACC_W = 40;
  localparam int REG_W = 32;
  localparam int HALF_W = 16;
  localparam int GUARD_W = 8;
  localparam int GUARD_LSB = 32;
  localparam int GUARD_MSB = 39;
  localparam int UPPER_LSB = 16;
  localparam int UPPER_MSB = 31;
  localparam int SIGN_BIT = 31;
  localparam int NUM_ACC = 2;
  localparam int NUM_GEN = 6;

  // reset values
  localparam logic [ACC_W-1:0] ACC_RST = 40'h00_0000_0000;
  localparam logic [REG_W-1:0] GEN_RST = 32'h0000_0000;
  localparam logic [HALF_W-1:0] LOW_ZERO = 16'h0000;
  localparam logic [GUARD_W-1:0] GUARD_ZERO = 8'h00;

  // slots of the non-accumulator registers
  localparam logic [2:0] GEN_XIN0 = 3'h0;
  localparam logic [2:0] GEN_YIN0 = 3'h2;
  localparam logic [2:0] GEN_MUL0 = 3'h4;

  typedef enum logic [3:0] {
    accum_zero, accum_one, accum_zero_guard, accum_one_guard,
    xin_zero, xin_one, yin_zero, yin_one, mulin_zero, mulin_one
  } drf_reg_e;

  typedef enum logic [2:0] {
    op_fixed, op_integer, op_logical, msb_detect, arith_shift, logic_shift, signed_multiply
  } drf_op_e;

  function automatic logic drf_is_acc(input drf_reg_e r);
    return (r == accum_zero) || (r == accum_one);
  endfunction : drf_is_acc

  function automatic logic drf_is_guard(input drf_reg_e r);
    return (r == accum_zero_guard) || (r == accum_one_guard);
  endfunction : drf_is_guard

  function automatic logic drf_is_gen(input drf_reg_e r);
    return (r >= xin_zero) && (r <= mulin_one);
  endfunction : drf_is_gen

  function automatic logic [2:0] drf_gen_idx(input drf_reg_e r);
    logic [3:0] d;
    d = 4'(r) - 4'(xin_zero);
    return d[2:0];
  endfunction : drf_gen_idx

  // operations that keep the full 32/40-bit width
  function automatic logic drf_is_wide(input drf_op_e op);
    return (op == op_fixed) || (op == msb_detect) || (op == arith_shift);
  endfunction : drf_is_wide

endpackage : drf_pkg

/* design/drf_src_shaper.sv */
`timescale 1ns/1ps
`default_nettype none

module drf_src_shaper (
  // operation
  input wire drf_pkg::drf_op_e op,
  input wire logic from_acc,
  // raw register contents, non-accumulators in the low 32 bits
  input wire logic [drf_pkg::ACC_W-1:0] raw,
  // shaped operand toward the alu
  output logic [drf_pkg::ACC_W-1:0] shaped
);
  import drf_pkg::*;

  logic [GUARD_W-1:0] guard;
  logic [HALF_W-1:0] upper;

  // (RULE13) guard taken from storage
  // (RULE9) guard from sign otherwise
  assign guard = from_acc ? raw[GUARD_MSB:GUARD_LSB] : {GUARD_W{raw[SIGN_BIT]}};
  assign upper = raw[UPPER_MSB:UPPER_LSB];

  always_comb begin
    // (RULE8) width per operation class
    if (drf_is_wide(op)) begin
      shaped = {guard, raw[REG_W-1:0]};
    end else if (op == op_integer) begin
      shaped = {guard, upper, LOW_ZERO};
    end else begin
      shaped = {GUARD_ZERO, upper, LOW_ZERO};
    end
  end

endmodule : drf_src_shaper

`default_nettype wire

/* design/drf_regfile.sv */
// Overview of operation
// (RULE1) word single load: upper half, low cleared
// (RULE2) accumulator word load also sign-fills guard
// (RULE3) guard load writes low 8 bits only
// (RULE4) guard store sign-extends its 8 bits
// (RULE5) long store: 32 bits, guard excluded
// (RULE6) long load: 32 bits, accumulator guard sign-filled
// (RULE7) signed multiply refuses accumulator zero source
// (RULE8) accumulator source width: 40, 24, 16
// (RULE9) other sources sign-fill alu guard bits
// (RULE10) integer/msb result: 24 bits, sign guard
// (RULE11) logical result: upper half, rest cleared
// (RULE12) other destinations: 32 or 16 bit results
// (RULE13) accumulator guard bits valid in fixed-point
// (RULE14) x/y bus load: upper half, low cleared
// (RULE15) guard registers alias accumulator top byte
// (RULE16) shaping applied in the access cycle
`timescale 1ns/1ps
`default_nettype none

module drf_regfile (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // single data transfer port
  input wire logic st_valid,
  input wire logic st_load,
  input wire logic st_long,
  input wire drf_pkg::drf_reg_e st_reg,
  input wire logic [drf_pkg::REG_W-1:0] st_wdata,
  output logic st_rvalid,
  output logic [drf_pkg::REG_W-1:0] st_rdata,
  // x bus word transfer
  input wire logic xb_valid,
  input wire logic xb_load,
  input wire logic xb_sel,
  input wire logic [drf_pkg::HALF_W-1:0] xb_wdata,
  output logic xb_rvalid,
  output logic [drf_pkg::HALF_W-1:0] xb_rdata,
  // y bus word transfer
  input wire logic yb_valid,
  input wire logic yb_load,
  input wire logic yb_sel,
  input wire logic [drf_pkg::HALF_W-1:0] yb_wdata,
  output logic yb_rvalid,
  output logic [drf_pkg::HALF_W-1:0] yb_rdata,
  // alu operand fetch
  input wire logic op_valid,
  input wire drf_pkg::drf_op_e op_kind,
  input wire drf_pkg::drf_reg_e op_src_a,
  input wire drf_pkg::drf_reg_e op_src_b,
  output logic op_ovalid,
  output logic op_illegal,
  output logic [drf_pkg::ACC_W-1:0] alu_src_a,
  output logic [drf_pkg::ACC_W-1:0] alu_src_b,
  // alu result write-back
  input wire logic res_valid,
  input wire drf_pkg::drf_op_e res_kind,
  input wire drf_pkg::drf_reg_e res_dst,
  input wire logic [drf_pkg::ACC_W-1:0] res_data,
  output logic res_illegal
);
  import drf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // storage

  // (RULE15) guard is the accumulator top byte
  logic [ACC_W-1:0] acc_q [NUM_ACC];
  logic [ACC_W-1:0] acc_d [NUM_ACC];
  logic [REG_W-1:0] gen_q [NUM_GEN];
  logic [REG_W-1:0] gen_d [NUM_GEN];

  logic st_wr;
  logic st_rd;
  logic res_ok;
  logic src_a_ok;
  logic src_b_ok;

  assign st_wr = st_valid && st_load;
  assign st_rd = st_valid && !st_load;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic drf_reg_e acc_name(input logic i);
    return i ? accum_one : accum_zero;
  endfunction : acc_name

  function automatic drf_reg_e guard_name(input logic i);
    return i ? accum_one_guard : accum_zero_guard;
  endfunction : guard_name

  function automatic logic [REG_W-1:0] upper_word(input logic [HALF_W-1:0] d);
    return {d, LOW_ZERO};
  endfunction : upper_word

  // (RULE7) per-instruction source limits
  function automatic logic src_legal(input drf_op_e op, input drf_reg_e r);
    if (drf_is_guard(r)) begin
      return 1'b0;
    end
    if ((op == signed_multiply) && (r == accum_zero)) begin
      return 1'b0;
    end
    return drf_is_acc(r) || drf_is_gen(r);
  endfunction : src_legal

  function automatic logic [ACC_W-1:0] raw_of(input drf_reg_e r, input logic [ACC_W-1:0] a0,
                                              input logic [ACC_W-1:0] a1, input logic [REG_W-1:0] g);
    if (r == accum_zero) begin
      return a0;
    end
    if (r == accum_one) begin
      return a1;
    end
    return {GUARD_ZERO, g};
  endfunction : raw_of

  assign res_ok = res_valid && (drf_is_acc(res_dst) || drf_is_gen(res_dst));
  assign src_a_ok = src_legal(op_kind, op_src_a);
  assign src_b_ok = src_legal(op_kind, op_src_b);

  ////////////////////////////////////////////////////////////////////////
  // accumulator next value; the alu result wins over a same-cycle load

  always_comb begin
    for (int i = 0; i < NUM_ACC; i++) begin
      acc_d[i] = acc_q[i];
      if (st_wr && (st_reg == acc_name(i[0]))) begin
        if (st_long) begin
          // (RULE6) long load, sign-filled guard
          acc_d[i] = {{GUARD_W{st_wdata[SIGN_BIT]}}, st_wdata};
        end else begin
          // (RULE2) word load into accumulator
          acc_d[i] = {{GUARD_W{st_wdata[HALF_W-1]}}, upper_word(st_wdata[HALF_W-1:0])};
        end
      end
      // (RULE3) guard load keeps other bits
      if (st_wr && (st_reg == guard_name(i[0]))) begin
        acc_d[i][GUARD_MSB:GUARD_LSB] = st_wdata[GUARD_W-1:0];
      end
      if (res_ok && (res_dst == acc_name(i[0]))) begin
        if (res_kind == op_fixed || res_kind == arith_shift || res_kind == signed_multiply) begin
          // (RULE13) guard bits written in full
          acc_d[i] = res_data;
        end else if (res_kind == op_integer || res_kind == msb_detect) begin
          // (RULE10) 24-bit result, sign guard
          acc_d[i] = {{GUARD_W{res_data[SIGN_BIT]}}, upper_word(res_data[UPPER_MSB:UPPER_LSB])};
        end else begin
          // (RULE11) logical result, guard cleared
          acc_d[i] = {GUARD_ZERO, upper_word(res_data[UPPER_MSB:UPPER_LSB])};
        end
      end
    end
  end

  // (RULE16) shaped value stored on this edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_ACC; i++) begin
        acc_q[i] <= ACC_RST;
      end
    end else begin
      for (int i = 0; i < NUM_ACC; i++) begin
        acc_q[i] <= acc_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input/multiplier registers; priority alu, single, x bus, y bus

  always_comb begin
    for (int k = 0; k < NUM_GEN; k++) begin
      gen_d[k] = gen_q[k];
    end
    // (RULE14) bus word load to upper half
    if (yb_valid && yb_load) begin
      gen_d[3'(GEN_YIN0 + 3'(yb_sel))] = upper_word(yb_wdata);
    end
    if (xb_valid && xb_load) begin
      gen_d[3'(GEN_XIN0 + 3'(xb_sel))] = upper_word(xb_wdata);
    end
    if (st_wr && drf_is_gen(st_reg)) begin
      // (RULE1) word load clears low half
      // (RULE6) long load writes 32 bits
      gen_d[drf_gen_idx(st_reg)] = st_long ? st_wdata : upper_word(st_wdata[HALF_W-1:0]);
    end
    if (res_ok && drf_is_gen(res_dst)) begin
      // (RULE12) guard of result dropped
      if (res_kind == op_fixed || res_kind == arith_shift || res_kind == signed_multiply) begin
        gen_d[drf_gen_idx(res_dst)] = res_data[REG_W-1:0];
      end else begin
        gen_d[drf_gen_idx(res_dst)] = upper_word(res_data[UPPER_MSB:UPPER_LSB]);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < NUM_GEN; k++) begin
        gen_q[k] <= GEN_RST;
      end
    end else begin
      for (int k = 0; k < NUM_GEN; k++) begin
        gen_q[k] <= gen_d[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // single transfer store data

  logic [REG_W-1:0] st_rdata_d;
  logic [ACC_W-1:0] st_raw;

  // full raw word; only its low 32 bits leave on a store
  assign st_raw = raw_of(st_reg, acc_q[0], acc_q[1], gen_q[drf_gen_idx(st_reg)]);

  always_comb begin
    st_rdata_d = GEN_RST;
    if (drf_is_guard(st_reg)) begin
      // (RULE4) guard store sign-extended
      st_rdata_d = {{(REG_W-GUARD_W){acc_q[st_reg == accum_one_guard][GUARD_MSB]}},
                    acc_q[st_reg == accum_one_guard][GUARD_MSB:GUARD_LSB]};
    end else if (drf_is_acc(st_reg) || drf_is_gen(st_reg)) begin
      // (RULE5) 32 bits, guard left out
      st_rdata_d = st_raw[REG_W-1:0];
      if (!st_long) begin
        st_rdata_d = {{HALF_W{st_rdata_d[SIGN_BIT]}}, st_rdata_d[UPPER_MSB:UPPER_LSB]};
      end
    end
  end

  // store data registered so the bus sees a clean value
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_rvalid <= 1'b0;
      st_rdata <= GEN_RST;
    end else begin
      st_rvalid <= st_rd;
      if (st_rd) begin
        st_rdata <= st_rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // x/y bus stores: only accumulator upper words can leave

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      xb_rvalid <= 1'b0;
      yb_rvalid <= 1'b0;
      xb_rdata <= LOW_ZERO;
      yb_rdata <= LOW_ZERO;
    end else begin
      xb_rvalid <= xb_valid && !xb_load;
      yb_rvalid <= yb_valid && !yb_load;
      if (xb_valid && !xb_load) begin
        xb_rdata <= acc_q[xb_sel][UPPER_MSB:UPPER_LSB];
      end
      if (yb_valid && !yb_load) begin
        yb_rdata <= acc_q[yb_sel][UPPER_MSB:UPPER_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alu operand fetch

  logic [ACC_W-1:0] shaped_a;
  logic [ACC_W-1:0] shaped_b;

  // (RULE8) accumulator width by class
  drf_src_shaper u_shape_a (
    .op(op_kind),
    .from_acc(drf_is_acc(op_src_a)),
    .raw(raw_of(op_src_a, acc_q[0], acc_q[1], gen_q[drf_gen_idx(op_src_a)])),
    .shaped(shaped_a)
  );

  // (RULE9) sign-filled guard for others
  drf_src_shaper u_shape_b (
    .op(op_kind),
    .from_acc(drf_is_acc(op_src_b)),
    .raw(raw_of(op_src_b, acc_q[0], acc_q[1], gen_q[drf_gen_idx(op_src_b)])),
    .shaped(shaped_b)
  );

  // operands held on refusal so the alu never sees a banned register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op_ovalid <= 1'b0;
      op_illegal <= 1'b0;
      alu_src_a <= ACC_RST;
      alu_src_b <= ACC_RST;
    end else begin
      // (RULE7) refuse illegal source choice
      op_ovalid <= op_valid && src_a_ok && src_b_ok;
      op_illegal <= op_valid && !(src_a_ok && src_b_ok);
      if (op_valid && src_a_ok && src_b_ok) begin
        alu_src_a <= shaped_a;
        alu_src_b <= shaped_b;
      end
    end
  end

  // guard names and unused codes are not alu destinations
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      res_illegal <= 1'b0;
    end else begin
      res_illegal <= res_valid && !res_ok;
    end
  end

endmodule : drf_regfile

`default_nettype wire

/* sim/drf_regfile_props.sv */
`timescale 1ns/1ps
`default_nettype none
module drf_regfile_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // transfers
  input wire logic st_valid,
  input wire logic st_load,
  input wire drf_pkg::drf_reg_e st_reg,
  input wire logic st_rvalid,
  input wire logic [31:0] st_rdata,
  input wire logic xb_valid,
  input wire logic xb_load,
  input wire logic xb_rvalid,
  // alu side
  input wire logic op_valid,
  input wire drf_pkg::drf_op_e op_kind,
  input wire drf_pkg::drf_reg_e op_src_a,
  input wire drf_pkg::drf_reg_e op_src_b,
  input wire logic op_ovalid,
  input wire logic op_illegal,
  input wire logic [39:0] alu_src_a,
  input wire logic res_valid,
  input wire drf_pkg::drf_reg_e res_dst,
  input wire logic res_illegal
);
  import drf_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_store; st_valid && !st_load; endsequence
  sequence s_mul; op_valid && op_kind == signed_multiply; endsequence
  ////////////////////////////////////////
  chk_store_answer: assert property (s_store |=> st_rvalid)
    else $error("store gave no answer");
  chk_store_quiet: assert property (!(st_valid && !st_load) |=> !st_rvalid)
    else $error("answer without store");
  chk_guard_sext: assert property (s_store ##0 st_reg inside {accum_zero_guard, accum_one_guard}
    |=> st_rdata[31:8] == {24{st_rdata[7]}}) else $error("guard store not sign extended");
  chk_mul_refuse: assert property (s_mul ##0 (op_src_a == accum_zero || op_src_b == accum_zero)
    |=> op_illegal && !op_ovalid) else $error("accumulator zero taken by multiply");
  chk_mul_accept: assert property (s_mul ##0 op_src_a == accum_one && op_src_b == accum_one
    |=> op_ovalid && !op_illegal) else $error("accumulator one refused by multiply");
  chk_narrow_src: assert property (op_valid && op_kind inside {op_logical, logic_shift, signed_multiply}
    |=> op_ovalid |-> alu_src_a[39:32] == 8'h00 && alu_src_a[15:0] == 16'h0000) else $error("narrow operand");
  chk_int_low: assert property (op_valid && op_kind == op_integer
    |=> op_ovalid |-> alu_src_a[15:0] == 16'h0000) else $error("integer operand low half");
  chk_gen_sext: assert property (op_valid && op_kind == op_fixed && op_src_a inside {[xin_zero:mulin_one]}
    |=> op_ovalid |-> alu_src_a[39:32] == {8{alu_src_a[31]}}) else $error("operand guard not sign");
  chk_guard_dst: assert property (res_valid && res_dst inside {accum_zero_guard, accum_one_guard}
    |=> res_illegal) else $error("guard result not refused");
  chk_bus_answer: assert property (xb_valid && !xb_load |=> xb_rvalid)
    else $error("bus store gave no answer");
endmodule : drf_regfile_props
bind drf_regfile drf_regfile_props u_props (.mclk, .rst_n, .st_valid, .st_load, .st_reg, .st_rvalid,
  .st_rdata, .xb_valid, .xb_load, .xb_rvalid, .op_valid, .op_kind, .op_src_a, .op_src_b, .op_ovalid,
  .op_illegal, .alu_src_a, .res_valid, .res_dst, .res_illegal);
`default_nettype wire

/* sim/drf_alu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module drf_alu_model (
  // clock
  input wire logic mclk,
  // result write-back
  output logic res_valid,
  output drf_pkg::drf_op_e res_kind,
  output drf_pkg::drf_reg_e res_dst,
  output logic [39:0] res_data
);
  import drf_pkg::*;
  initial begin
    res_valid = 1'b0;
    res_kind = op_fixed;
    res_dst = accum_zero;
    res_data = 40'h00_0000_0000;
  end
  // lag of at least one keeps two drives apart
  task automatic deliver(input drf_op_e k, input drf_reg_e d, input logic [39:0] v, input int lag);
    repeat (lag) @(negedge mclk);
    res_kind = k;
    res_dst = d;
    res_data = v;
    res_valid = 1'b1;
    @(negedge mclk);
    res_valid = 1'b0;
    res_data = ~v;
  endtask : deliver
endmodule : drf_alu_model
`default_nettype wire

/* sim/drf_regfile_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module drf_regfile_tb;
  import drf_pkg::*;
  logic mclk, rst_n, st_valid, st_load, st_long, st_rvalid, xb_valid, xb_load, xb_sel, xb_rvalid;
  logic yb_valid, yb_load, yb_sel, yb_rvalid, op_valid, op_ovalid, op_illegal, res_valid, res_illegal;
  drf_reg_e st_reg, op_src_a, op_src_b, res_dst;
  drf_op_e op_kind, res_kind;
  logic [31:0] st_wdata, st_rdata, rs, d, e, gr[6];
  logic [15:0] xb_wdata, xb_rdata, yb_wdata, yb_rdata;
  logic [39:0] alu_src_a, alu_src_b, res_data, acc[2], last_a, last_b;
  logic [3:0] r;
  logic [31:0] qs[$];
  logic [15:0] qx[$], qy[$];
  logic [81:0] qo[$];
  logic qr[$];
  int miscompares, total_checks;
  drf_regfile dut (.mclk, .rst_n, .st_valid, .st_load, .st_long, .st_reg, .st_wdata, .st_rvalid, .st_rdata,
    .xb_valid, .xb_load, .xb_sel, .xb_wdata, .xb_rvalid, .xb_rdata, .yb_valid, .yb_load, .yb_sel, .yb_wdata,
    .yb_rvalid, .yb_rdata, .op_valid, .op_kind, .op_src_a, .op_src_b, .op_ovalid, .op_illegal, .alu_src_a,
    .alu_src_b, .res_valid, .res_kind, .res_dst, .res_data, .res_illegal);
  drf_alu_model alu (.mclk, .res_valid, .res_kind, .res_dst, .res_data);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  function automatic logic [39:0] raw(input logic [3:0] x);
    if (x < 4'h2) return acc[x[0]];
    if (x > 4'h3 && x < 4'hA) return {{8{gr[x-4'h4][31]}}, gr[x-4'h4]};
    return 40'h00_0000_0000;
  endfunction : raw
  function automatic logic [39:0] srcv(input drf_op_e k, input logic [3:0] x);
    logic [39:0] v;
    v = raw(x);
    if (k inside {op_fixed, msb_detect, arith_shift}) return v;
    if (k == op_integer) return {v[39:16], 16'h0000};
    return {8'h00, v[31:16], 16'h0000};
  endfunction : srcv
  function automatic logic [31:0] stv(input logic [3:0] x, input logic lng);
    logic [39:0] v;
    v = raw(x);
    if (x inside {4'h2, 4'h3}) return {{24{acc[x[0]][39]}}, acc[x[0]][39:32]};
    return lng ? v[31:0] : {{16{v[31]}}, v[31:16]};
  endfunction : stv
  task automatic chk(input logic [81:0] seen, input logic [81:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic sx(input logic ld, input logic lng, input logic [3:0] x, input logic [31:0] w);
    @(negedge mclk);
    st_valid = 1'b1;
    st_load = ld;
    st_long = lng;
    st_reg = drf_reg_e'(x);
    st_wdata = w;
    if (!ld) qs.push_back(stv(x, lng));
    else if (x < 4'h2) acc[x[0]] = lng ? {{8{w[31]}}, w} : {{8{w[15]}}, w[15:0], 16'h0000};
    else if (x < 4'h4) acc[x[0]][39:32] = w[7:0];
    else if (x < 4'hA) gr[x-4'h4] = lng ? w : {w[15:0], 16'h0000};
    @(negedge mclk);
    st_valid = 1'b0;
  endtask : sx
  task automatic bx(input logic ld, input logic sx_, input logic sy, input logic [31:0] w);
    @(negedge mclk);
    {xb_valid, yb_valid, xb_load, yb_load, xb_sel, yb_sel} = {2'b11, ld, ld, sx_, sy};
    {yb_wdata, xb_wdata} = w;
    if (ld) gr[sx_] = {w[15:0], 16'h0000};
    if (ld) gr[2 + sy] = {w[31:16], 16'h0000};
    if (!ld) qx.push_back(acc[sx_][31:16]);
    if (!ld) qy.push_back(acc[sy][31:16]);
    @(negedge mclk);
    {xb_valid, yb_valid} = 2'b00;
  endtask : bx
  task automatic ox(input drf_op_e k, input logic [3:0] a, input logic [3:0] b);
    logic bad;
    @(negedge mclk);
    bad = a inside {[4'h2:4'h3], [4'hA:4'hF]} || b inside {[4'h2:4'h3], [4'hA:4'hF]};
    bad = bad || (k == signed_multiply && (a == 4'h0 || b == 4'h0));
    if (!bad) {last_a, last_b} = {srcv(k, a), srcv(k, b)};
    op_valid = 1'b1;
    op_kind = k;
    op_src_a = drf_reg_e'(a);
    op_src_b = drf_reg_e'(b);
    qo.push_back({!bad, bad, last_a, last_b});
    @(negedge mclk);
    op_valid = 1'b0;
  endtask : ox
  task automatic rx(input drf_op_e k, input logic [3:0] x, input logic [39:0] w, input int lag);
    logic [39:0] v;
    v = {{8{w[31]}}, w[31:16], 16'h0000};
    if (k inside {op_logical, logic_shift}) v[39:32] = 8'h00;
    if (k inside {op_fixed, arith_shift, signed_multiply}) v = w;
    if (x inside {[4'h2:4'h3], [4'hA:4'hF]}) qr.push_back(1'b1);
    else if (x < 4'h2) acc[x[0]] = v;
    else gr[x-4'h4] = v[31:0];
    alu.deliver(k, drf_reg_e'(x), w, lag);
  endtask : rx
  always @(negedge mclk) begin
    if (st_rvalid === 1'b1) chk(st_rdata, qs.pop_front());
    if (xb_rvalid === 1'b1) chk(xb_rdata, qx.pop_front());
    if (yb_rvalid === 1'b1) chk(yb_rdata, qy.pop_front());
    if (op_ovalid === 1'b1 || op_illegal === 1'b1) begin
      chk({op_ovalid, op_illegal, alu_src_a, alu_src_b}, qo.pop_front());
    end
    if (res_illegal === 1'b1) chk(res_illegal, qr.pop_front());
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (6000) @(posedge mclk);
    miscompares++;
    finish_test();
  end
  initial begin
    {rs, rst_n, miscompares, total_checks, last_a, last_b} = {32'h5907, 1'b0, 64'h0, 80'h0};
    {st_valid, st_load, st_long, xb_valid, xb_load, xb_sel, yb_valid, yb_load, yb_sel, op_valid} = '0;
    {st_wdata, xb_wdata, yb_wdata} = '0;
    st_reg = accum_zero;
    op_src_a = accum_zero;
    op_src_b = accum_zero;
    op_kind = op_fixed;
    acc = '{2{40'h00_0000_0000}};
    gr = '{6{32'h0000_0000}};
    repeat (10) @(posedge mclk);
    @(negedge mclk) rst_n = 1'b1;
    chk({st_rvalid, st_rdata, op_ovalid, op_illegal, alu_src_a}, '0);
    $display("test reset finished");
    repeat (60) begin
      r = 4'(rnd() % 11);
      sx(1'b1, rs[20], r, rnd());
      sx(1'b0, rs[9], r, 32'h0000_0000);
      sx(1'b0, rs[3], r ^ 4'h2, 32'h0000_0000);
    end
    $display("test single transfer finished");
    repeat (20) begin
      d = rnd();
      bx(1'b1, d[5], d[6], d);
      bx(1'b0, d[7], d[8], 32'h0000_0000);
      sx(1'b0, 1'b1, 4'(4 + 2 * d[9] + d[10]), 32'h0000_0000);
    end
    $display("test bus transfer finished");
    for (int k = 0; k < 7; k++) for (int a = 0; a < 13; a++) ox(drf_op_e'(k), 4'(a), 4'(12 - a));
    ox(signed_multiply, 4'h1, 4'h1);
    $display("test operand fetch finished");
    repeat (40) begin
      d = rnd();
      e = rnd();
      rx(drf_op_e'(d % 7), 4'(e % 11), {d[7:0], e}, d[8] ? 4 : 1);
      ox(op_fixed, 4'(e % 11), 4'h1);
      sx(1'b0, 1'b1, 4'(e % 11), 32'h0000_0000);
    end
    $display("test result write finished");
    repeat (3) @(negedge mclk);
    chk(qs.size() + qx.size() + qy.size() + qo.size() + qr.size(), 0);
    finish_test();
  end
endmodule : drf_regfile_tb
`default_nettype wire
